// file: core/wws_pkg.sv
// Constants, timing counts and the pin carrier for the window watchdog supervisor.
// Assumes a single 100 MHz clock; the internal oscillator is derived from it.
//
// Contract
// - Full window is 5000 oscillator periods; a fault pulse lasts one period.
// - Each regular window is a closed half followed by an open half.
// - After initialization a single open window of eight full windows comes first.
// - Service in an open window restarts counting with a closed window.
// - A kick during a closed window registers a fault.
// - Any open window ending without a kick registers a fault.
// - The watchdog runs only while the active-low enable is low.
// - Rising reset output while enabled initializes the watchdog.
// - Pulsed variant drives the fault output low one pulse time per fault.
// - Pulsed variant finishes a started fault pulse even when disabled.
// - Flag variant latches the flag high and pulses reset output low.
// - Flag clears on re-enable, or about 5 us after proper service.
// - Flag stays low without fault and clears when reset output drops.
// - Flag variant reset pulse runs full length even when disabled.
// - Reset output rises only after regulation plus the power-on delay.
package wws_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 10;
    localparam int WINDOW_OSC_PERIODS = 5000;
    localparam int HALF_OSC_PERIODS   = WINDOW_OSC_PERIODS / 2;
    localparam int FIRST_OSC_PERIODS  = 8 * WINDOW_OSC_PERIODS;
    localparam int DEGLITCH_TIME_NS   = 5500;
    localparam int DEGLITCH_CYC       = DEGLITCH_TIME_NS / CLK_PERIOD_NS;
    localparam int FLAG_CLEAR_NS      = 5000;
    localparam int FLAG_CLEAR_CYC     = FLAG_CLEAR_NS / CLK_PERIOD_NS;
    localparam int POR_DELAY_NS       = 250000;
    localparam int POR_DELAY_CYC      = POR_DELAY_NS / CLK_PERIOD_NS;
    localparam int OSC_DIV_DEFAULT    = 100;
    localparam int WCNT_W             = 16;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        WWS_IDLE   = 3'b000,
        WWS_FIRST  = 3'b001,
        WWS_CLOSED = 3'b010,
        WWS_OPEN   = 3'b011,
        WWS_HOLD   = 3'b100
    } wws_state_e;

    typedef struct packed {
        logic supervisor_enable_n;
        logic kick_input;
        logic power_ok;
    } wws_pins_s;

    localparam wws_pins_s PINS_RESET = '{supervisor_enable_n: 1'b1,
                                         kick_input: 1'b0, power_ok: 1'b0};

endpackage

// file: core/wws_sync.sv
// Three-stage synchronizer with agreement filter for asynchronous pins.
// Assumes inputs are static levels from outside the clock domain.
`timescale 1ns/1ps
module wws_sync #(
    parameter int                 W         = 3,
    parameter logic [W-1:0]       RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [W-1:0]     din,
    output logic      [W-1:0]     dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Stage one feeds only stage two, to keep metastability contained
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            dout <= RESET_VAL;
        else
            dout <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & dout);
    end
endmodule

// file: core/wws_supervisor.sv
// Window watchdog supervisor with power-good reset output.
// Assumes pins arrive asynchronously; the oscillator is a divider of clk.
`timescale 1ns/1ps
module wws_supervisor #(
    parameter bit FLAG_VARIANT  = 1'b0,
    parameter int OSC_DIV       = wws_pkg::OSC_DIV_DEFAULT,
    parameter int POR_DELAY_CYC = wws_pkg::POR_DELAY_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic supervisor_enable_n,
    input  wire logic kick_input,
    input  wire logic power_ok,
    output logic      power_good_reset_n,
    output logic      fault_pulse_out,
    output logic      fault_latch_out
);
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam int POR_W = $clog2(POR_DELAY_CYC + wws_pkg::DEGLITCH_CYC + 1);
    localparam int CLR_W = $clog2(wws_pkg::FLAG_CLEAR_CYC + 1);
    localparam int WCW = wws_pkg::WCNT_W;
    localparam logic [WCW-1:0] HALF_LAST  = WCW'(wws_pkg::HALF_OSC_PERIODS - 1);
    localparam logic [WCW-1:0] FIRST_LAST = WCW'(wws_pkg::FIRST_OSC_PERIODS - 1);

    // One clock per oscillator period is the fastest the pulse counter serves
    initial
    begin
        if (OSC_DIV < 1 || POR_DELAY_CYC < 1)
            $error("wws_supervisor: OSC_DIV must be >= 1, POR_DELAY_CYC >= 1");
    end

    // ****************************************************************
    // Input synchronization and edges
    // ****************************************************************
    wws_pkg::wws_pins_s pins_raw;
    wws_pkg::wws_pins_s pins;
    assign pins_raw = '{supervisor_enable_n: supervisor_enable_n,
                        kick_input: kick_input, power_ok: power_ok};

    wws_sync #(.W(3), .RESET_VAL(wws_pkg::PINS_RESET)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (pins_raw),
        .dout  (pins)
    );

    logic en;
    logic en_prev_q;
    logic kick_prev_q;
    logic por_ok_q;
    logic por_prev_q;
    assign en = ~pins.supervisor_enable_n;

    // Previous levels for edge detection
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_prev_q   <= 1'b0;
            kick_prev_q <= 1'b0;
            por_prev_q  <= 1'b0;
        end
        else
        begin
            en_prev_q   <= en;
            kick_prev_q <= pins.kick_input;
            por_prev_q  <= por_ok_q;
        end
    end

    logic kick_rise;
    logic en_fall_n;
    logic por_rise;
    assign kick_rise = pins.kick_input & ~kick_prev_q;
    assign en_fall_n = en & ~en_prev_q;
    assign por_rise  = por_ok_q & ~por_prev_q;

    // ****************************************************************
    // Power-on delay and deglitch
    // ****************************************************************
    logic [POR_W-1:0] por_cnt_q;
    logic [POR_W-1:0] por_last;
    assign por_last = pins.power_ok ? POR_W'(POR_DELAY_CYC - 1)
                                    : POR_W'(wws_pkg::DEGLITCH_CYC - 1);

    // Level must disagree for the full delay before it is taken
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            por_ok_q  <= 1'b0;
            por_cnt_q <= '0;
        end
        else if (pins.power_ok == por_ok_q)
            por_cnt_q <= '0;
        else if (por_cnt_q == por_last)
        begin
            por_ok_q  <= pins.power_ok;
            por_cnt_q <= '0;
        end
        else
            por_cnt_q <= por_cnt_q + POR_W'(1);
    end

    // ****************************************************************
    // Oscillator and fault pulse timing
    // ****************************************************************
    logic [DIV_W-1:0] div_q;
    logic             tick;
    assign tick = (div_q == DIV_W'(OSC_DIV - 1));

    // Free-running oscillator; window phase may slip up to one period
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            div_q <= '0;
        else
            div_q <= tick ? '0 : div_q + DIV_W'(1);
    end

    logic             fault;
    logic             service;
    logic             pulse_act_q;
    logic [DIV_W-1:0] pulse_cnt_q;
    logic             pulse_end;
    assign pulse_end = pulse_act_q && (pulse_cnt_q == DIV_W'(OSC_DIV - 1));

    // Pulse length is one oscillator period and ignores enable
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_act_q <= 1'b0;
            pulse_cnt_q <= '0;
        end
        else if (fault)
        begin
            pulse_act_q <= 1'b1;
            pulse_cnt_q <= '0;
        end
        else if (pulse_end)
            pulse_act_q <= 1'b0;
        else if (pulse_act_q)
            pulse_cnt_q <= pulse_cnt_q + DIV_W'(1);
    end

    // ****************************************************************
    // Window sequencer
    // ****************************************************************
    wws_pkg::wws_state_e         st_q;
    logic [wws_pkg::WCNT_W-1:0]  wcnt_q;
    logic                        run;
    logic                        init;
    logic                        at_half;
    logic                        at_first;
    assign run      = en && por_ok_q;
    assign init     = (por_rise && en)
                    || (en_fall_n && por_ok_q)
                    || (!FLAG_VARIANT && pulse_end && run);
    assign at_half  = tick && (wcnt_q == HALF_LAST);
    assign at_first = tick && (wcnt_q == FIRST_LAST);

    // Fault and service decisions for this cycle
    always_comb
    begin
        fault   = 1'b0;
        service = 1'b0;
        if (run && !init)
        begin
            case (st_q)
                wws_pkg::WWS_FIRST:
                begin
                    service = kick_rise;
                    fault   = !kick_rise && at_first;
                end
                wws_pkg::WWS_CLOSED: fault = kick_rise;
                wws_pkg::WWS_OPEN:
                begin
                    service = kick_rise;
                    fault   = !kick_rise && at_half;
                end
                default: ;
            endcase
        end
    end

    // State and window counter; a kick ends its phase, so one per phase
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q   <= wws_pkg::WWS_IDLE;
            wcnt_q <= '0;
        end
        else if (!run)
        begin
            st_q   <= wws_pkg::WWS_IDLE;
            wcnt_q <= '0;
        end
        else if (init)
        begin
            st_q   <= wws_pkg::WWS_FIRST;
            wcnt_q <= '0;
        end
        else if (fault)
        begin
            st_q   <= FLAG_VARIANT ? wws_pkg::WWS_CLOSED : wws_pkg::WWS_HOLD;
            wcnt_q <= '0;
        end
        else if (service)
        begin
            st_q   <= wws_pkg::WWS_CLOSED;
            wcnt_q <= '0;
        end
        else if (st_q == wws_pkg::WWS_CLOSED && at_half)
        begin
            st_q   <= wws_pkg::WWS_OPEN;
            wcnt_q <= '0;
        end
        else if (tick && st_q != wws_pkg::WWS_IDLE && st_q != wws_pkg::WWS_HOLD)
            wcnt_q <= wcnt_q + wws_pkg::WCNT_W'(1);
    end

    // ****************************************************************
    // Outputs and flag
    // ****************************************************************
    logic             flag_q;
    logic             clr_act_q;
    logic [CLR_W-1:0] clr_cnt_q;
    logic             clr_done;
    assign clr_done = clr_act_q && (clr_cnt_q == CLR_W'(wws_pkg::FLAG_CLEAR_CYC - 1));

    // Delayed clear after proper service while the flag stands
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clr_act_q <= 1'b0;
            clr_cnt_q <= '0;
        end
        else if (!flag_q || !run || fault)
            clr_act_q <= 1'b0;
        else if (service && !clr_act_q)
        begin
            clr_act_q <= 1'b1;
            clr_cnt_q <= '0;
        end
        else if (clr_done)
            clr_act_q <= 1'b0;
        else if (clr_act_q)
            clr_cnt_q <= clr_cnt_q + CLR_W'(1);
    end

    // Set wins over every clear source
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flag_q <= 1'b0;
        else if (FLAG_VARIANT && fault)
            flag_q <= 1'b1;
        else if (!por_ok_q || en_fall_n || clr_done)
            flag_q <= 1'b0;
    end

    // Registered pins; one clock behind the internal pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_good_reset_n <= 1'b0;
            fault_pulse_out    <= 1'b1;
            fault_latch_out    <= 1'b0;
        end
        else
        begin
            power_good_reset_n <= por_ok_q && !(FLAG_VARIANT && pulse_act_q);
            fault_pulse_out    <= !(!FLAG_VARIANT && pulse_act_q);
            fault_latch_out    <= flag_q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    pulse_start_a: assert property (fault |=> pulse_act_q && pulse_cnt_q == '0)
        else $error("fault did not start a pulse");
    pulse_hold_a: assert property (pulse_act_q && !pulse_end |=> pulse_act_q)
        else $error("fault pulse ended early");
    closed_kick_a: assert property (run && !init && st_q == wws_pkg::WWS_CLOSED && kick_rise
        |-> fault)
        else $error("closed window kick not faulted");
    open_timeout_a: assert property (run && !init && st_q == wws_pkg::WWS_OPEN && at_half
        && !kick_rise |-> fault)
        else $error("open window timeout not faulted");
    init_first_a: assert property (run && init |=> st_q == wws_pkg::WWS_FIRST && wcnt_q == '0)
        else $error("init did not open first window");
    closed_to_open_a: assert property (run && !init && st_q == wws_pkg::WWS_CLOSED && at_half
        && !kick_rise |=> st_q == wws_pkg::WWS_OPEN)
        else $error("closed window did not open");
    service_close_a: assert property (service |=> st_q == wws_pkg::WWS_CLOSED && wcnt_q == '0)
        else $error("service did not start closed window");
    disabled_idle_a: assert property (!en |=> st_q == wws_pkg::WWS_IDLE)
        else $error("watchdog ran while disabled");
    flag_set_a: assert property (FLAG_VARIANT && fault |=> flag_q ##1 fault_latch_out)
        else $error("flag not latched");
    flag_power_a: assert property (!por_ok_q && !fault |=> !flag_q)
        else $error("flag kept across reset output drop");
    rst_pulse_a: assert property (FLAG_VARIANT && pulse_act_q |=> !power_good_reset_n)
        else $error("reset output not pulsed");
    fault_pin_a: assert property (!FLAG_VARIANT && $rose(pulse_act_q)
        |=> !fault_pulse_out && !power_good_reset_n == !por_prev_q)
        else $error("fault pin not low during pulse");

    fault_seen_c:   cover property (fault);
    flag_clear_c:   cover property (flag_q && clr_done);
    pulse_reinit_c: cover property (!FLAG_VARIANT && pulse_end && run);
endmodule

// file: verif/wws_mcu_model.sv
// Microcontroller model: drives the watchdog enable pin and the kick pin.
// Assumes the bench commands it by kick_req pulses and an en_req level.
`timescale 1ns/1ps
module wws_mcu_model #(
    parameter int HOLD_CYC = 12
) (
    input  wire logic clk,
    input  wire logic kick_req,
    input  wire logic en_req,
    output logic      supervisor_enable_n,
    output logic      kick_input
);
    // ********************
    // Pin drive
    // ********************
    int hold_q;

    // Disabled at time zero, as a controller that has not booted yet
    initial supervisor_enable_n = 1'b1;

    // Pins move just after the edge; a kick stays up well past the filter
    always @(posedge clk)
    begin
        supervisor_enable_n <= !en_req;
        if (kick_req)
            hold_q <= HOLD_CYC;
        else if (hold_q > 0)
            hold_q <= hold_q - 1;
    end

    // One rising edge per command, so one kick per window phase
    assign kick_input = (hold_q > 0);
endmodule

// file: verif/tb_top.sv
// Self-checking bench: pulsed and flag variants side by side on shared pins.
// Assumes the design package is compiled first; one clock per oscillator period.
`timescale 1ns/1ps
module tb_top;
    localparam int OSCD = 1;
    localparam int PORD = 20;
    localparam int W    = wws_pkg::WINDOW_OSC_PERIODS * OSCD;
    localparam int H    = wws_pkg::HALF_OSC_PERIODS * OSCD;
    localparam int F    = wws_pkg::FIRST_OSC_PERIODS * OSCD;
    localparam int DG   = wws_pkg::DEGLITCH_CYC;
    localparam int LAT  = 7;

    logic clk      = 1'b0;
    logic rst_b    = 1'b0;
    logic power_ok = 1'b1;
    logic kick_req = 1'b0;
    logic en_req   = 1'b0;
    logic supervisor_enable_n;
    logic kick_input;
    logic p_rst_n;
    logic p_flt_n;
    logic p_flag;
    logic f_rst_n;
    logic f_flt_n;
    logic f_flag;
    logic p_old;
    int   cyc, p_run, p_at, p_len, p_cnt, f_run, f_at, f_len, f_cnt, p_up, p_dn;
    int   bad_count, samples_checked, k, t0, n0, i, sp, sf;

    // ********************
    // Clock, partner and designs
    // ********************
    initial forever #5 clk = ~clk;

    wws_mcu_model #(.HOLD_CYC(3 * OSCD + 6)) wws_mcu_model_inst (
        .clk(clk), .kick_req(kick_req), .en_req(en_req),
        .supervisor_enable_n(supervisor_enable_n), .kick_input(kick_input));

    wws_supervisor #(.FLAG_VARIANT(1'b0), .OSC_DIV(OSCD), .POR_DELAY_CYC(PORD))
        wws_supervisor_inst (
        .clk(clk), .rst_b(rst_b), .supervisor_enable_n(supervisor_enable_n),
        .kick_input(kick_input), .power_ok(power_ok), .power_good_reset_n(p_rst_n),
        .fault_pulse_out(p_flt_n), .fault_latch_out(p_flag));

    // Second instance is the flag variant; its name departs from the usual form
    wws_supervisor #(.FLAG_VARIANT(1'b1), .OSC_DIV(OSCD), .POR_DELAY_CYC(PORD))
        wws_supervisor_f_inst (
        .clk(clk), .rst_b(rst_b), .supervisor_enable_n(supervisor_enable_n),
        .kick_input(kick_input), .power_ok(power_ok), .power_good_reset_n(f_rst_n),
        .fault_pulse_out(f_flt_n), .fault_latch_out(f_flag));

    // ********************
    // Monitors
    // ********************
    // Low runs of the fault pin and of the flag variant's reset pin
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        p_old <= p_rst_n;
        if (p_rst_n === 1'b1 && p_old !== 1'b1)
            p_up <= cyc;
        if (p_rst_n === 1'b0 && p_old === 1'b1)
            p_dn <= cyc;
        if (p_flt_n === 1'b0)
        begin
            if (p_run == 0)
                p_at <= cyc;
            p_run <= p_run + 1;
        end
        else if (p_run != 0)
        begin
            p_len <= p_run;
            p_cnt <= p_cnt + 1;
            p_run <= 0;
        end
        if (f_rst_n === 1'b0)
        begin
            if (f_run == 0)
                f_at <= cyc;
            f_run <= f_run + 1;
        end
        else if (f_run != 0)
        begin
            f_len <= f_run;
            f_cnt <= f_cnt + 1;
            f_run <= 0;
        end
    end

    // ********************
    // Tasks and expectations
    // ********************
    // Every drive lands 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic kick();
        kick_req = 1'b1;
        k = cyc;
        step(1);
        kick_req = 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, e, s);
        end
    endtask

    task automatic rng(input string what, input int lo, input int hi, input int s);
        samples_checked++;
        if (s < lo || s > hi)
        begin
            bad_count++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, s);
        end
    endtask

    // Bounded wait for the end of the next fault pulse
    task automatic wait_flt(input int bound);
        n0 = p_cnt;
        for (i = 0; i < bound && p_cnt == n0; i++)
            step(1);
        step(4);
    endtask

    // Kick reaches the pin one edge late, then three flops, filter, state or pulse flop, output flop
    function automatic int exp_at(input int t, input int span);
        return t + span + LAT;
    endfunction

    task automatic reinit();
        en_req = 1'b0;
        step(100);
        en_req = 1'b1;
        step(20);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ********************
    // Tests
    // ********************
    // Watchdog sized for about 68k cycles of tests plus margin
    initial
    begin
        repeat (95000) @(posedge clk);
        bad_count++;
        $display("BAD run_time expected done seen timeout");
        give_verdict();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h5C41));
        step(2);
        rst_b = 1'b1;
        t0 = cyc;
        step(PORD + 40);
        rng("por_rise", t0 + PORD, t0 + PORD + 15, p_up);
        chk("flt_idle", 32'h1, p_flt_n);
        chk("flag_idle", 32'h0, f_flag);
        sp = p_cnt;
        sf = f_cnt;
        repeat (3)
        begin
            kick();
            step(300);
        end
        chk("off_p", sp, p_cnt);
        chk("off_f", sf, f_cnt);
        $display("test power_up done");

        en_req = 1'b1;
        step(20);
        step(200 + $urandom_range(1800));
        kick();
        step(H + 150);
        kick();
        step(W - 150);
        kick();
        step(H + 200 + $urandom_range(H - 400));
        kick();
        chk("svc_p", sp, p_cnt);
        chk("svc_f", sf, f_cnt);
        chk("svc_flag", 32'h0, f_flag);
        $display("test service done");

        step(500 + $urandom_range(H - 900));
        kick();
        wait_flt(200);
        rng("closed_at", k, k + 20, p_at);
        chk("pulse_len", OSCD, p_len);
        chk("rst_len", OSCD, f_len);
        chk("flag_set", 32'h1, f_flag);
        step(H / 2);
        kick();
        step(200);
        chk("reinit_p", sp + 1, p_cnt);
        chk("noreinit_f", sf + 2, f_cnt);
        reinit();
        chk("flag_reen", 32'h0, f_flag);
        $display("test closed_kick done");

        sp = p_cnt;
        step(300 + $urandom_range(1500));
        kick();
        t0 = k;
        wait_flt(W + 100);
        rng("open_p", exp_at(t0, W) - 8, exp_at(t0, W) + 8, p_at);
        rng("open_f", exp_at(t0, W) - 8, exp_at(t0, W) + 8, f_at);
        step(H + 1500);
        kick();
        step(400);
        chk("flag_hold", 32'h1, f_flag);
        step(200);
        chk("flag_svc", 32'h0, f_flag);
        chk("after_p", sp + 1, p_cnt);
        $display("test open_timeout done");

        step(100);
        kick();
        wait_flt(200);
        chk("flag_again", 32'h1, f_flag);
        power_ok = 1'b0;
        t0 = cyc;
        step(DG + 40);
        rng("drop", t0 + DG, t0 + DG + 20, p_dn);
        chk("flag_drop", 32'h0, f_flag);
        power_ok = 1'b1;
        t0 = cyc;
        sp = p_cnt;
        step(PORD + 40);
        rng("rerise", t0 + PORD, t0 + PORD + 20, p_up);
        wait_flt(F + 200);
        rng("first_p", p_up + F - 8, p_up + F + 12, p_at);
        rng("first_f", p_up + F - 8, p_up + F + 12, f_at);
        chk("first_cnt", sp + 1, p_cnt);
        chk("pulsed_latch", 32'h0, p_flag);
        chk("flag_pin", 32'h1, f_flt_n);
        $display("test power_cycle done");
        give_verdict();
    end
endmodule
